// ---- logic/dtx_control_regs.sv ----
// Control and status register bank of the display transmitter, with the
// control outputs that the pixel path, DACs and link transmitter consume.
// Assumes a serial port front end that delivers single-byte register
// writes and reads on the core clock; all pins are synchronous.
`timescale 1ns/1ps

// What this block does
// - Format code from three bits plus MSB
// - Polarity bits set sync active level
// - Embedded sync replaces pins, format four
// - Sense holds DACs steady, no sync
// - Sense release latches termination status
// - Hot-plug pin level readable anytime
// - Low hot-plug pin shuts link drivers
// - Disable bit stops automatic shutdown
// - Hot-plug change pulls shared interrupt low while link runs
// - Bypass sends pixels straight to DACs
// - Sync pins driven only when enabled
// - Control symbols sent during sync
// - Invert bit inverts link outputs
// - Two-bit field selects test pattern
// - Datapath held reset while bit zero
// - Register reset bit zero forces defaults
// - Full power-down stops DACs, link, sync pins, datapath, IRQ
// - Per-DAC power-down bits, zero means on
// - Link runs with both power bits
module dtx_control_regs
    import dtx_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_reg_wr,
    input  wire logic       i_reg_rd,
    input  wire logic [7:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    output logic [7:0]      o_reg_rdata,
    output logic            o_reg_rvalid,
    input  wire dtx_sync_t  i_sync_pins,
    input  wire dtx_sync_t  i_sync_embedded,
    input  wire logic       i_hpd_pin,
    input  wire logic [2:0] i_dac_compare,
    output logic [3:0]      o_input_format,
    output logic            o_embedded_sync,
    output dtx_sync_t       o_sync,
    output dtx_sync_t       o_dac_sync,
    output logic            o_dac_steady,
    output logic            o_dac_bypass,
    output logic [1:0]      o_dac_gain,
    output logic [2:0]      o_dac_power_on,
    output dtx_sync_t       o_sync_pin_out,
    output logic            o_sync_pin_oe,
    output logic            o_irq_pin_out,
    output logic            o_irq_pin_oe,
    output logic            o_link_power_on,
    output logic            o_link_drive_en,
    output logic            o_output_invert,
    output logic [3:0]      o_link_ctrl_symbols,
    output dtx_pll_cfg_t    o_pll_cfg,
    output logic [1:0]      o_pattern_select,
    output logic            o_datapath_rst_n
);

    logic [7:0] regs [NREG];
    logic [NREG-1:0] addr_hit;

    logic       soft_reset_n;
    logic       hp_level;
    logic       hp_irq;
    logic       sense_steady;
    logic [2:0] term_status;
    logic [7:0] hw_bits;
    logic [7:0] rd_val;

    // force defaults while low
    // Self-clearing: the reload puts a one back in this bit
    assign soft_reset_n = regs[IX_RES][B_REG_RST_N];

    // Register bank: one entry per mapped offset
    // One address decode serves both writes and reads
    for (genvar g = 0; g < NREG; g++) begin : g_reg
        assign addr_hit[g] = (i_reg_addr == REG_OFF[g]);
        wire sel = i_reg_wr && addr_hit[g];
        always_ff @(posedge i_core_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                regs[g] <= REG_RST[g];
            end else if (!soft_reset_n) begin
                regs[g] <= REG_RST[g];
            end else if (sel) begin
                // Read-only status bits drop what is written
                // reserved bits kept as written
                regs[g] <= i_reg_wdata & ~REG_RO[g];
            end
        end
    end

    // Hardware-owned bits of the connection register
    // Not stored, so a read always sees the live state
    assign hw_bits = {2'b00, hp_level, 1'b0, term_status, 1'b0};

    // Unmapped offsets read as zero
    always_comb begin
        rd_val = RD_UNMAPPED;
        for (int i = 0; i < NREG; i++) begin
            if (addr_hit[i]) begin
                rd_val = (regs[i] & ~REG_RO[i]) | (hw_bits & REG_RO[i]);
            end
        end
    end

    // Decoded control fields
    wire       full_power_down        = regs[IX_PM][B_FPD];
    wire [2:0] dac_power_down      = regs[IX_PM][B_DAC_POWER_DOWN_LO +: 3];
    wire       link_a     = regs[IX_PM][B_LINK_A];
    wire       link_b     = regs[IX_PM][B_LINK_B];
    wire       sense_bit  = regs[IX_CONN][B_SENSE];
    wire       irq_en     = regs[IX_CONN][B_HOTPLUG_IRQ_ENABLE];
    wire       auto_shutdown_disable       = regs[IX_HPHW][B_AUTO_SHUTDOWN_DISABLE];
    wire       sync_output_enable      = regs[IX_DACC][B_SYNC_OUTPUT_ENABLE];
    wire       rearm      = regs[IX_REARM][B_REARM];

    // Plain control fields passed on to the outputs
    wire       bypass_bit    = regs[IX_DACC][B_BYPASS];
    wire [1:0] gain_field    = regs[IX_DACC][B_GAIN_LO +: 2];
    wire [1:0] pattern_field = regs[IX_RES][1:0];
    wire       dp_run        = regs[IX_RES][B_DP_RST_N];
    wire       invert_bit    = regs[IX_PLLP][B_INVERT];
    wire [3:0] ctl_symbols   = regs[IX_LCTL][3:0];

    wire [3:0] fmt_code = {regs[IX_DACC][B_FMT_MSB], regs[IX_IFMT][2:0]};

    // Only that format carries sync codes in the stream
    // embedded sync only for format four
    wire use_emb = regs[IX_IFMT][B_DES] && (fmt_code == FMT_EMBEDDED);

    wire pin_h = i_sync_pins.h ^ ~regs[IX_IFMT][B_HSP];
    wire pin_v = i_sync_pins.v ^ ~regs[IX_IFMT][B_VSP];

    // Both sync sources are active high from here on
    dtx_sync_t next_sync;
    assign next_sync.h = use_emb ? i_sync_embedded.h : pin_h;
    assign next_sync.v = use_emb ? i_sync_embedded.v : pin_v;

    // link alive needs both power bits
    wire link_run = link_a && link_b && !full_power_down;

    // The disable bit lets a host keep the drivers on
    // shutdown on low pin unless disabled
    wire next_link_drive = link_run && (hp_level || auto_shutdown_disable);

    // full power-down overrides each DAC bit
    // otherwise one power-down bit per DAC
    wire [2:0] next_dac_on = full_power_down ? 3'h0 : ~dac_power_down;

    // Pins are released in full power-down as well
    // sync pins only when enabled
    wire next_sync_oe = sync_output_enable && !full_power_down;

    // datapath held in reset during full power-down too
    wire next_dp_run = dp_run && !full_power_down;

    dtx_sync_t next_dac_sync;
    assign next_dac_sync = sense_steady ? '0 : next_sync;

    // PLL fields pass through; the host owns their values
    dtx_pll_cfg_t next_pll;
    assign next_pll.charge_pump     = regs[IX_PLLP][0];
    assign next_pll.post_div        = regs[IX_PLLP][B_PSD_LO +: 2];
    assign next_pll.drive_level     = regs[IX_PLLP][B_DRV_LO +: 3];
    assign next_pll.feedback_div    = regs[IX_PLLD][3:0];
    assign next_pll.feedforward_div = regs[IX_PLLD][B_FFD_LO +: 2];
    assign next_pll.filter          = regs[IX_PLLF][B_LPF_LO +: 4];

    // Gated off while the link is down, so nothing stays pending
    // interrupt only while link is selected
    dtx_hotplug u_hotplug (
        .i_core_clk   (i_core_clk),
        .i_rst_n      (i_rst_n),
        .i_hpd_pin    (i_hpd_pin),
        .i_irq_enable (irq_en && link_run),
        .i_rearm      (rearm),
        .o_level      (hp_level),
        .o_irq        (hp_irq)
    );

    // Status reads zero until the first sense pass
    // termination capture
    dtx_sense u_sense (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_sense    (sense_bit),
        .i_compare  (i_dac_compare),
        .o_steady   (sense_steady),
        .o_status   (term_status)
    );

    // Read answer one cycle after the strobe
    // Data holds until the next read
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_reg_rdata  <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                o_reg_rdata <= rd_val;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_input_format  <= 4'h0;
            o_embedded_sync <= 1'b0;
            o_sync          <= '0;
        end else begin
            o_input_format  <= fmt_code;
            o_embedded_sync <= use_emb;
            o_sync          <= next_sync;
        end
    end

    // sense state and gated analogue sync
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_dac_sync   <= '0;
            o_dac_steady <= 1'b0;
        end else begin
            o_dac_sync   <= next_dac_sync;
            o_dac_steady <= sense_steady;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_dac_bypass   <= 1'b0;
            o_dac_gain     <= 2'h0;
            o_dac_power_on <= 3'h0;
        end else begin
            o_dac_bypass   <= bypass_bit;
            o_dac_gain     <= gain_field;
            o_dac_power_on <= next_dac_on;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pattern_select <= 2'h0;
            o_datapath_rst_n <= 1'b0;
        end else begin
            o_pattern_select <= pattern_field;
            o_datapath_rst_n <= next_dp_run;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sync_pin_out <= '0;
            o_sync_pin_oe  <= 1'b0;
        end else begin
            o_sync_pin_out <= next_sync;
            o_sync_pin_oe  <= next_sync_oe;
        end
    end

    // open drain interrupt, only ever pulls low
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq_pin_out <= 1'b0;
            o_irq_pin_oe  <= 1'b0;
        end else begin
            o_irq_pin_out <= 1'b0;
            o_irq_pin_oe  <= hp_irq;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_link_power_on     <= 1'b0;
            o_link_drive_en     <= 1'b0;
            o_output_invert     <= 1'b0;
            o_link_ctrl_symbols <= 4'h0;
            o_pll_cfg           <= '0;
        end else begin
            o_link_power_on     <= link_run;
            o_link_drive_en     <= next_link_drive;
            o_output_invert     <= invert_bit;
            o_link_ctrl_symbols <= ctl_symbols;
            o_pll_cfg           <= next_pll;
        end
    end

endmodule

// ---- logic/dtx_pkg.sv ----
// Constants, register map and carrier types for the display transmitter control bank.
// Assumes one core clock domain and a byte-wide register access port.
package dtx_pkg;

    localparam int NREG = 11;

    // Register indices into the flip-flop bank
    localparam int IX_REARM = 0;
    localparam int IX_IFMT  = 1;
    localparam int IX_CONN  = 2;
    localparam int IX_DACC  = 3;
    localparam int IX_HPHW  = 4;
    localparam int IX_LCTL  = 5;
    localparam int IX_PLLP  = 6;
    localparam int IX_PLLD  = 7;
    localparam int IX_PLLF  = 8;
    localparam int IX_RES   = 9;
    localparam int IX_PM    = 10;

    localparam logic [7:0] REG_OFF [NREG] = '{
        8'h1E, 8'h1F, 8'h20, 8'h21, 8'h23, 8'h31, 8'h33, 8'h34, 8'h36, 8'h48, 8'h49};
    localparam logic [7:0] REG_RST [NREG] = '{
        8'hC0, 8'h80, 8'h00, 8'h00, 8'h00, 8'h80, 8'hE4, 8'h16, 8'h00, 8'h18, 8'h01};
    // Bits owned by hardware; writes to them are dropped
    localparam logic [7:0] REG_RO  [NREG] = '{
        8'h00, 8'h00, 8'h2E, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    // Field positions
    localparam int B_REARM     = 3;
    localparam int B_HSP       = 3;
    localparam int B_VSP       = 4;
    localparam int B_DES       = 6;
    localparam int B_SENSE     = 0;
    localparam int B_TERM_LO   = 1;
    localparam int B_HOTPLUG_PIN_LEVEL      = 5;
    localparam int B_HOTPLUG_IRQ_ENABLE      = 7;
    localparam int B_BYPASS    = 0;
    localparam int B_GAIN_LO   = 1;
    localparam int B_SYNC_OUTPUT_ENABLE     = 3;
    localparam int B_FMT_MSB   = 5;
    localparam int B_AUTO_SHUTDOWN_DISABLE      = 2;
    localparam int B_INVERT    = 4;
    localparam int B_PSD_LO    = 2;
    localparam int B_DRV_LO    = 5;
    localparam int B_FFD_LO    = 4;
    localparam int B_LPF_LO    = 4;
    localparam int B_DP_RST_N  = 3;
    localparam int B_REG_RST_N = 4;
    localparam int B_FPD       = 0;
    localparam int B_DAC_POWER_DOWN_LO  = 1;
    localparam int B_LINK_A    = 7;
    localparam int B_LINK_B    = 6;

    localparam logic [3:0] FMT_EMBEDDED = 4'h4;
    localparam logic [7:0] RD_UNMAPPED  = 8'h00;

    typedef struct packed {
        logic h;
        logic v;
    } dtx_sync_t;

    typedef struct packed {
        logic       charge_pump;
        logic [1:0] post_div;
        logic [2:0] drive_level;
        logic [3:0] feedback_div;
        logic [1:0] feedforward_div;
        logic [3:0] filter;
    } dtx_pll_cfg_t;

endpackage

// ---- logic/dtx_hotplug.sv ----
// Hot-plug pin level tracking and change interrupt with rearm.
// Assumes the pin is already synchronous to the core clock.
`timescale 1ns/1ps
module dtx_hotplug (
    input  wire logic i_core_clk,
    input  wire logic i_rst_n,
    input  wire logic i_hpd_pin,
    input  wire logic i_irq_enable,
    input  wire logic i_rearm,
    output logic      o_level,
    output logic      o_irq
);
    logic prev;
    logic pending;
    logic change;

    assign change = (i_hpd_pin != prev);

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev    <= 1'b0;
            o_level <= 1'b0;
            pending <= 1'b0;
            o_irq   <= 1'b0;
        end else begin
            prev    <= i_hpd_pin;
            o_level <= i_hpd_pin;
            // change sets, set wins over rearm
            // Dropping the enable also drops a pending event, so none fires late
            pending <= i_irq_enable && (change || (pending && !i_rearm));
            o_irq   <= i_irq_enable && (change || (pending && !i_rearm));
        end
    end
endmodule

// ---- logic/dtx_sense.sv ----
// DAC connection-sense sequencer: steady drive while sensing, capture on release.
// Assumes comparator results are valid and synchronous when sense drops.
`timescale 1ns/1ps
module dtx_sense (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_sense,
    input  wire logic [2:0] i_compare,
    output logic            o_steady,
    output logic [2:0]      o_status
);
    logic sense_q;
    logic release_edge;

    assign release_edge = sense_q && !i_sense;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sense_q  <= 1'b0;
            o_steady <= 1'b0;
            o_status <= 3'h0;
        end else begin
            sense_q  <= i_sense;
            o_steady <= i_sense;
            if (release_edge) begin
                o_status <= i_compare;
            end
        end
    end
endmodule

// ---- sim/dtx_control_regs_assertions.sv ----
// Port checker for the display transmitter control bank.
// Assumes the bank's top ports only; bound from the testbench top file.
`timescale 1ns/1ps
module dtx_control_regs_assertions
    import dtx_pkg::*;
(
    input wire logic       i_core_clk,
    input wire logic       i_rst_n,
    input wire logic       i_reg_wr,
    input wire logic       i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire logic       i_hpd_pin,
    input wire logic [3:0] o_input_format,
    input wire dtx_sync_t  o_sync,
    input wire dtx_sync_t  o_dac_sync,
    input wire logic       o_dac_steady,
    input wire logic       o_dac_bypass,
    input wire logic [2:0] o_dac_power_on,
    input wire dtx_sync_t  o_sync_pin_out,
    input wire logic       o_sync_pin_oe,
    input wire logic       o_irq_pin_out,
    input wire logic       o_irq_pin_oe,
    input wire logic       o_link_power_on,
    input wire logic [1:0] o_pattern_select,
    input wire logic       o_datapath_rst_n
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    logic [7:0] wd1;
    logic [7:0] wd2;
    // Write data two edges back, lined up with registered outputs
    always_ff @(posedge i_core_clk) begin
        wd1 <= i_reg_wdata;
        wd2 <= wd1;
    end
    fmt_code_a: assert property (i_reg_wr && i_reg_addr == 8'h1F |-> ##2 o_input_format[2:0] == wd2[2:0])
        else $error("format code wrong");
    bypass_out_a: assert property (i_reg_wr && i_reg_addr == 8'h21 |-> ##2 o_dac_bypass == wd2[0])
        else $error("bypass wrong");
    power_out_a: assert property (i_reg_wr && i_reg_addr == 8'h49 |-> ##2
        (o_dac_power_on == (wd2[0] ? 3'h0 : ~wd2[3:1])) && (o_link_power_on == (wd2[7] & wd2[6] & ~wd2[0])))
        else $error("power outputs wrong");
    soft_reset_a: assert property (i_reg_wr && i_reg_addr == 8'h48 && !i_reg_wdata[4] |->
        ##3 o_pattern_select == 2'h0 && !o_datapath_rst_n && o_dac_power_on == 3'h0)
        else $error("soft reset missed");
    steady_nosync_a: assert property (o_dac_steady |-> o_dac_sync == 2'h0)
        else $error("sync during sense");
    sync_pin_a: assert property (o_sync_pin_oe |-> o_sync_pin_out == o_sync)
        else $error("sync pin differs");
    level_read_a: assert property (i_reg_rd && i_reg_addr == 8'h20 |=> o_reg_rdata[5] == $past(i_hpd_pin, 2))
        else $error("pin level read wrong");
    irq_cause_a: assert property ($rose(o_irq_pin_oe) |-> $past(i_hpd_pin, 2) != $past(i_hpd_pin, 3))
        else $error("interrupt without change");
    irq_low_a: assert property (o_irq_pin_out == 1'b0)
        else $error("interrupt pin driven high");
    cover property (o_dac_steady);
    cover property ($rose(o_irq_pin_oe));
    cover property (o_link_power_on && o_sync_pin_oe);
endmodule

// ---- sim/dtx_host_model.sv ----
// Host controller model: single-byte writes and reads on the strobe port.
// Assumes requests move 1 ns after a rising edge; read data one cycle later.
`timescale 1ns/1ps
module dtx_host_model (
    input  wire logic       i_core_clk,
    input  wire logic [7:0] i_rdata,
    input  wire logic       i_rvalid,
    output logic            o_wr,
    output logic            o_rd,
    output logic [7:0]      o_addr,
    output logic [7:0]      o_wdata
);
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 8'h00;
        o_wdata = 8'h00;
    end
    // Released lines flip so stale data never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        #1;
        o_wr = 1'b1;
        o_addr = a;
        o_wdata = d;
        @(posedge i_core_clk);
        #1;
        o_wr = 1'b0;
        o_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_core_clk);
        #1;
        o_rd = 1'b1;
        o_addr = a;
        @(posedge i_core_clk);
        #1;
        o_rd = 1'b0;
        o_addr = ~a;
        d = i_rvalid ? i_rdata : 8'hXX;
    endtask
    task automatic prep_sense();
        wr(8'h49, 8'h00);
        wr(8'h21, 8'h00);
    endtask
    task automatic rearm();
        wr(8'h49, 8'hC0);
        wr(8'h1E, 8'hC8);
        wr(8'h1E, 8'hC0);
    endtask
    task automatic pll_fast();
        wr(8'h33, 8'h04);
        wr(8'h34, 8'h26);
        wr(8'h36, 8'hA0);
    endtask
endmodule

// ---- sim/dtx_control_regs_tb.sv ----
// Self-checking bench: host model on the register port, pins driven here.
// Assumes a 125 MHz core clock and the checker bound below.
`timescale 1ns/1ps
module dtx_control_regs_tb;
    import dtx_pkg::*;
    logic         i_core_clk, i_rst_n, i_reg_wr, i_reg_rd, i_hpd_pin, o_reg_rvalid, o_embedded_sync;
    logic         o_dac_steady, o_dac_bypass, o_sync_pin_oe, o_irq_pin_out, o_irq_pin_oe, o_link_power_on;
    logic         o_link_drive_en, o_output_invert, o_datapath_rst_n;
    logic [7:0]   i_reg_addr, i_reg_wdata, o_reg_rdata, rv;
    logic [2:0]   i_dac_compare, o_dac_power_on;
    logic [3:0]   o_input_format, o_link_ctrl_symbols;
    logic [1:0]   o_dac_gain, o_pattern_select;
    dtx_sync_t    i_sync_pins, i_sync_embedded, o_sync, o_dac_sync, o_sync_pin_out;
    dtx_pll_cfg_t o_pll_cfg;
    int           mismatches, n_tests;

    dtx_control_regs dut_u (.i_core_clk, .i_rst_n, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
        .o_reg_rdata, .o_reg_rvalid, .i_sync_pins, .i_sync_embedded, .i_hpd_pin, .i_dac_compare,
        .o_input_format, .o_embedded_sync, .o_sync, .o_dac_sync, .o_dac_steady, .o_dac_bypass, .o_dac_gain,
        .o_dac_power_on, .o_sync_pin_out, .o_sync_pin_oe, .o_irq_pin_out, .o_irq_pin_oe, .o_link_power_on,
        .o_link_drive_en, .o_output_invert, .o_link_ctrl_symbols, .o_pll_cfg, .o_pattern_select,
        .o_datapath_rst_n);
    dtx_host_model host_u (.i_core_clk, .i_rdata(o_reg_rdata), .i_rvalid(o_reg_rvalid), .o_wr(i_reg_wr),
        .o_rd(i_reg_rd), .o_addr(i_reg_addr), .o_wdata(i_reg_wdata));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Outputs settle two edges after a write; three gives margin
    task automatic w3();
        repeat (3) @(posedge i_core_clk);
        #1;
    endtask
    task automatic t_reset();
        for (int i = 0; i < NREG; i++) begin
            host_u.rd(REG_OFF[i], rv);
            chk(rv, REG_RST[i]);
        end
        host_u.rd(8'h22, rv);
        chk(rv, RD_UNMAPPED);
        $display("test reset done");
    endtask
    task automatic t_format();
        i_sync_pins = 2'b11;
        i_sync_embedded = 2'b01;
        host_u.wr(8'h21, 8'h04);
        host_u.wr(8'h1F, 8'h4C);
        w3();
        chk(o_input_format, 4'h4);
        chk(o_embedded_sync, 1'b1);
        chk(o_sync, 2'b01);
        chk(o_dac_gain, 2'b10);
        host_u.wr(8'h21, 8'h20);
        w3();
        chk(o_input_format, 4'hC);
        chk(o_embedded_sync, 1'b0);
        chk(o_sync, 2'b10);
        i_sync_pins = 2'b10;
        w3();
        chk(o_sync, 2'b11);
        $display("test format done");
    endtask
    task automatic t_sense();
        host_u.prep_sense();
        host_u.wr(8'h20, 8'h01);
        w3();
        chk(o_dac_steady, 1'b1);
        chk(o_dac_sync, 2'b00);
        chk(o_dac_power_on, 3'h7);
        i_dac_compare = 3'b101;
        host_u.wr(8'h20, 8'h00);
        host_u.rd(8'h20, rv);
        chk(rv[3:1], 3'b101);
        w3();
        chk(o_dac_sync, 2'b01);
        host_u.wr(8'h49, 8'h0A);
        w3();
        chk(o_dac_power_on, 3'b010);
        host_u.wr(8'h49, 8'h0B);
        w3();
        chk(o_dac_power_on, 3'h0);
        $display("test sense done");
    endtask
    task automatic t_hotplug();
        host_u.wr(8'h49, 8'hC0);
        host_u.wr(8'h20, 8'h80);
        i_hpd_pin = 1'b1;
        w3();
        chk(o_irq_pin_oe, 1'b1);
        chk(o_link_drive_en, 1'b1);
        chk(o_link_power_on, 1'b1);
        host_u.rd(8'h20, rv);
        chk(rv[5], 1'b1);
        host_u.rearm();
        w3();
        chk(o_irq_pin_oe, 1'b0);
        i_hpd_pin = 1'b0;
        w3();
        chk(o_irq_pin_oe, 1'b1);
        chk(o_link_drive_en, 1'b0);
        host_u.wr(8'h23, 8'h04);
        w3();
        chk(o_link_drive_en, 1'b1);
        host_u.rearm();
        host_u.wr(8'h20, 8'h00);
        i_hpd_pin = 1'b1;
        w3();
        chk(o_irq_pin_oe, 1'b0);
        $display("test hotplug done");
    endtask
    task automatic t_outputs();
        host_u.wr(8'h21, 8'h0F);
        host_u.wr(8'h31, 8'h85);
        host_u.pll_fast();
        host_u.wr(8'h36, 8'hAF);
        w3();
        chk(o_dac_bypass, 1'b1);
        chk(o_sync_pin_oe, 1'b1);
        chk(o_sync_pin_out, 2'b01);
        chk(o_link_ctrl_symbols, 4'h5);
        chk(o_pll_cfg, 16'h21AA);
        host_u.rd(8'h36, rv);
        chk(rv, 8'hAF);
        host_u.wr(8'h33, 8'h14);
        w3();
        chk(o_output_invert, 1'b1);
        for (int p = 0; p < 4; p++) begin
            host_u.wr(8'h48, 8'h18 | p[7:0]);
            w3();
            chk(o_pattern_select, p[1:0]);
            chk(o_datapath_rst_n, 1'b1);
        end
        host_u.wr(8'h48, 8'h13);
        w3();
        chk(o_datapath_rst_n, 1'b0);
        host_u.wr(8'h48, 8'h0B);
        w3();
        chk(o_pattern_select, 2'b00);
        host_u.rd(8'h49, rv);
        chk(rv, REG_RST[IX_PM]);
        $display("test outputs done");
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        i_core_clk = 1'b0;
        forever #4 i_core_clk = ~i_core_clk;
    end
    initial begin
        repeat (20000) @(posedge i_core_clk);
        mismatches++;
        give_verdict();
    end
    initial begin
        i_rst_n = 1'b0;
        i_hpd_pin = 1'b0;
        i_dac_compare = 3'h0;
        i_sync_pins = 2'b00;
        i_sync_embedded = 2'b00;
        mismatches = 0;
        n_tests = 0;
        repeat (5) @(posedge i_core_clk);
        #1;
        i_rst_n = 1'b1;
        t_reset();
        t_format();
        t_sense();
        t_hotplug();
        t_outputs();
        give_verdict();
    end
endmodule

bind dtx_control_regs dtx_control_regs_assertions chk_u (.i_core_clk, .i_rst_n, .i_reg_wr, .i_reg_rd,
    .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .i_hpd_pin, .o_input_format, .o_sync, .o_dac_sync, .o_dac_steady,
    .o_dac_bypass, .o_dac_power_on, .o_sync_pin_out, .o_sync_pin_oe, .o_irq_pin_out, .o_irq_pin_oe,
    .o_link_power_on, .o_pattern_select, .o_datapath_rst_n);
